/* File: design/tssl_pkg.sv */
package tssl_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] TSSL_CTRL_OFF = 12'h000;
   localparam logic [11:0] TSSL_INTERVAL_OFF = 12'h004;
   localparam logic [11:0] TSSL_SWTRIG_OFF = 12'h008;
   localparam logic [11:0] TSSL_STATUS_OFF = 12'h00C;
   localparam logic [11:0] TSSL_IRQ_STAT_OFF = 12'h010;
   localparam logic [11:0] TSSL_IRQ_EN_OFF = 12'h014;
   localparam logic [11:0] TSSL_IRQ_CLR_OFF = 12'h018;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int TSSL_CTRL_SRC_LSB = 0;
   localparam int TSSL_CTRL_PLAY_BIT = 2;
   localparam logic [31:0] TSSL_INTERVAL_RST = 32'h0001_E848;
   localparam int TSSL_IRQ_W = 4;
   localparam int TSSL_IRQ_TRIG = 0;
   localparam int TSSL_IRQ_COMM_FATAL = 1;
   localparam int TSSL_IRQ_CACHE_FATAL = 2;
   localparam int TSSL_IRQ_STALL = 3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int TSSL_CLK_MHZ = 125;
   localparam int TSSL_CLK_NS = 8;
   localparam int TSSL_MIN_INTERVAL_PS = 6660;
   localparam int TSSL_MAX_INTERVAL_S = 14;
   localparam longint TSSL_MAX_INTERVAL_CYC = longint'(TSSL_MAX_INTERVAL_S) * TSSL_CLK_MHZ * 1000000;
   localparam int TSSL_MIN_INTERVAL_CYC = (TSSL_MIN_INTERVAL_PS + TSSL_CLK_NS * 1000 - 1) / (TSSL_CLK_NS * 1000);
   localparam int TSSL_NOTRIG_MS = 100;
   localparam int TSSL_NOTRIG_CYC = TSSL_NOTRIG_MS * TSSL_CLK_MHZ * 1000;
   localparam int TSSL_BLINK_CYC = 6250000;
   localparam int TSSL_BREATH_CYC = 62500000;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TSSL_SRC_INTERNAL = 2'h0,
      TSSL_SRC_EXTERNAL = 2'h1,
      TSSL_SRC_SYSTEM = 2'h2,
      TSSL_SRC_SOFTWARE = 2'h3
   } tssl_src_t;

   typedef struct packed {
      logic green;
      logic red;
   } tssl_lamp_t;

   typedef struct packed {
      logic sfp_fail;
      logic eth_link;
      logic frame_activity;
      logic comm_fatal;
   } tssl_comm_in_t;

   typedef struct packed {
      logic cache_fatal;
      logic cache_stall;
   } tssl_play_in_t;

endpackage

/* File: design/tssl_pattern_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// shared blink and breathing waveforms for both lamps
// ----------------------------------------------------------------
module tssl_pattern_gen #(
   parameter int BLINK_CYC = 6250000,
   parameter int BREATH_CYC = 62500000
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // patterns
   output logic blink,
   output logic breathe
);
   import tssl_pkg::*;

   logic [31:0] blink_cnt_reg;
   logic [31:0] breath_cnt_reg;
   logic [7:0] pwm_cnt_reg;
   logic blink_reg;
   logic breath_dir_reg;
   logic [7:0] duty_reg;

   // square wave for blinking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blink_cnt_reg <= 32'h0;
         blink_reg <= 1'b0;
      end else if (blink_cnt_reg >= 32'(BLINK_CYC - 1)) begin
         blink_cnt_reg <= 32'h0;
         blink_reg <= ~blink_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h1;
      end
   end

   // triangle duty ramp for breathing, 256 steps each way
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         breath_cnt_reg <= 32'h0;
         duty_reg <= 8'h00;
         breath_dir_reg <= 1'b0;
      end else if (breath_cnt_reg >= 32'(BREATH_CYC / 512)) begin
         breath_cnt_reg <= 32'h0;
         if (!breath_dir_reg) begin
            if (duty_reg == 8'hFF) breath_dir_reg <= 1'b1;
            else duty_reg <= duty_reg + 8'h01;
         end else begin
            if (duty_reg == 8'h00) breath_dir_reg <= 1'b0;
            else duty_reg <= duty_reg - 8'h01;
         end
      end else begin
         breath_cnt_reg <= breath_cnt_reg + 32'h1;
      end
   end

   // pwm carrier
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pwm_cnt_reg <= 8'h00;
      else pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
   end

   assign blink = blink_reg;
   assign breathe = pwm_cnt_reg < duty_reg;
endmodule

`default_nettype wire

/* File: design/tssl_interval_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// internal periodic trigger generator
// ----------------------------------------------------------------
module tssl_interval_gen #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic enable,
   input wire logic [CNT_W-1:0] interval,
   // trigger out
   output logic tick
);
   import tssl_pkg::*;

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] limit;

   // clamp to the shortest period one clock allows
   assign limit = (interval < CNT_W'(TSSL_MIN_INTERVAL_CYC)) ? CNT_W'(TSSL_MIN_INTERVAL_CYC) : interval;

   // count one interval, pulse, restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (!enable) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (cnt_reg >= limit - CNT_W'(1)) begin
         cnt_reg <= '0;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + CNT_W'(1);
         tick <= 1'b0;
      end
   end
endmodule

`default_nettype wire

/* File: design/tssl_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tssl_top #(
   parameter int NOTRIG_CYC = tssl_pkg::TSSL_NOTRIG_CYC,
   parameter int BLINK_CYC = tssl_pkg::TSSL_BLINK_CYC,
   parameter int BREATH_CYC = tssl_pkg::TSSL_BREATH_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // trigger inputs
   input wire logic ext_trig_in,
   input wire logic sys_trig_in,
   // status inputs
   input wire tssl_pkg::tssl_comm_in_t comm_in,
   input wire tssl_pkg::tssl_play_in_t play_in,
   // outputs
   output logic playback_trigger,
   output tssl_pkg::tssl_lamp_t comm_status_lamp,
   output tssl_pkg::tssl_lamp_t playback_status_lamp,
   output logic irq
);
   import tssl_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   tssl_src_t src_reg;
   logic play_en_reg;
   logic [31:0] interval_reg;
   logic sw_trig_reg;
   logic [TSSL_IRQ_W-1:0] irq_stat_reg;
   logic [TSSL_IRQ_W-1:0] irq_en_reg;
   logic comm_fatal_reg;
   logic cache_fatal_reg;
   logic ext_prev_reg;
   logic sys_prev_reg;
   logic [31:0] notrig_cnt_reg;
   logic notrig_reg;
   logic int_tick;
   logic blink;
   logic breathe;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic trig_next;
   logic [TSSL_IRQ_W-1:0] irq_ev;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign addr_ok = (paddr == TSSL_CTRL_OFF) || (paddr == TSSL_INTERVAL_OFF) || (paddr == TSSL_SWTRIG_OFF)
      || (paddr == TSSL_STATUS_OFF) || (paddr == TSSL_IRQ_STAT_OFF) || (paddr == TSSL_IRQ_EN_OFF)
      || (paddr == TSSL_IRQ_CLR_OFF);
   assign pslverr = psel && penable && !addr_ok;

   // control register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_reg <= TSSL_SRC_INTERNAL;
         play_en_reg <= 1'b0;
         interval_reg <= TSSL_INTERVAL_RST;
         irq_en_reg <= '0;
      end else if (wr_en) begin
         case (paddr)
            TSSL_CTRL_OFF: begin
               src_reg <= tssl_src_t'(pwdata[TSSL_CTRL_SRC_LSB +: 2]);
               play_en_reg <= pwdata[TSSL_CTRL_PLAY_BIT];
            end
            TSSL_INTERVAL_OFF: interval_reg <= pwdata;
            TSSL_IRQ_EN_OFF: irq_en_reg <= pwdata[TSSL_IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // software trigger command strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sw_trig_reg <= 1'b0;
      else sw_trig_reg <= wr_en && (paddr == TSSL_SWTRIG_OFF) && pwdata[0];
   end

   // read mux, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            TSSL_CTRL_OFF: prdata <= {29'h0, play_en_reg, src_reg};
            TSSL_INTERVAL_OFF: prdata <= interval_reg;
            TSSL_STATUS_OFF: prdata <= {26'h0, notrig_reg, play_in.cache_stall, cache_fatal_reg,
               comm_fatal_reg, comm_in.eth_link, comm_in.sfp_fail};
            TSSL_IRQ_STAT_OFF: prdata <= {28'h0, irq_stat_reg};
            TSSL_IRQ_EN_OFF: prdata <= {28'h0, irq_en_reg};
            default: prdata <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // trigger selection
   // ----------------------------------------------------------------
   tssl_interval_gen #(
      .CNT_W(32)
   ) u_interval (
      .pclk(pclk),
      .presetn(presetn),
      .enable(src_reg == TSSL_SRC_INTERNAL),
      .interval(interval_reg),
      .tick(int_tick)
   );

   // edge history of ext and system inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_reg <= 1'b0;
         sys_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= ext_trig_in;
         sys_prev_reg <= sys_trig_in;
      end
   end

   // one source at a time
   always_comb begin
      case (src_reg)
         TSSL_SRC_INTERNAL: trig_next = int_tick;
         TSSL_SRC_EXTERNAL: trig_next = ext_trig_in && !ext_prev_reg;
         TSSL_SRC_SYSTEM: trig_next = sys_trig_in && !sys_prev_reg;
         TSSL_SRC_SOFTWARE: trig_next = sw_trig_reg;
         default: trig_next = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) playback_trigger <= 1'b0;
      else playback_trigger <= trig_next;
   end

   // ----------------------------------------------------------------
   // sticky fatal flags and trigger watchdog
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comm_fatal_reg <= 1'b0;
         cache_fatal_reg <= 1'b0;
      end else begin
         if (comm_in.comm_fatal) comm_fatal_reg <= 1'b1;
         if (play_in.cache_fatal) cache_fatal_reg <= 1'b1;
      end
   end

   // no trigger within the last window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         notrig_cnt_reg <= 32'h0;
         notrig_reg <= 1'b0;
      end else if (!play_en_reg || playback_trigger) begin
         notrig_cnt_reg <= 32'h0;
         notrig_reg <= 1'b0;
      end else if (notrig_cnt_reg >= 32'(NOTRIG_CYC - 1)) begin
         notrig_reg <= 1'b1;
      end else begin
         notrig_cnt_reg <= notrig_cnt_reg + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // lamps
   // ----------------------------------------------------------------
   tssl_pattern_gen #(
      .BLINK_CYC(BLINK_CYC),
      .BREATH_CYC(BREATH_CYC)
   ) u_pattern (
      .pclk(pclk),
      .presetn(presetn),
      .blink(blink),
      .breathe(breathe)
   );

   // communication lamp, fatal first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comm_status_lamp <= '0;
      end else if (comm_fatal_reg) begin
         comm_status_lamp <= '{green: 1'b0, red: 1'b1};
      end else if (comm_in.sfp_fail) begin
         comm_status_lamp <= '0;
      end else if (!comm_in.eth_link) begin
         comm_status_lamp <= '{green: breathe, red: 1'b0};
      end else if (comm_in.frame_activity) begin
         comm_status_lamp <= '{green: blink, red: 1'b0};
      end else begin
         comm_status_lamp <= '{green: 1'b1, red: 1'b0};
      end
   end

   // playback lamp, fatal over stall over green
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         playback_status_lamp <= '0;
      end else if (cache_fatal_reg) begin
         playback_status_lamp <= '{green: 1'b0, red: 1'b1};
      end else if (play_en_reg && play_in.cache_stall) begin
         playback_status_lamp <= '{green: 1'b0, red: blink};
      end else if (play_en_reg && notrig_reg) begin
         playback_status_lamp <= '{green: breathe, red: 1'b0};
      end else if (play_en_reg) begin
         playback_status_lamp <= '{green: 1'b1, red: 1'b0};
      end else begin
         playback_status_lamp <= '0;
      end
   end

   // ----------------------------------------------------------------
   // interrupts: sticky, set wins over clear
   // ----------------------------------------------------------------
   assign irq_ev = {play_en_reg && play_in.cache_stall, play_in.cache_fatal, comm_in.comm_fatal, playback_trigger};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= '0;
      end else if (wr_en && paddr == TSSL_IRQ_CLR_OFF) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata[TSSL_IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_ev;
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_ext_rise_trig: assert property (@(posedge pclk) disable iff (!presetn)
      (src_reg == TSSL_SRC_EXTERNAL && $rose(ext_trig_in) && $stable(src_reg)) |=> playback_trigger)
      else $error("external rising edge gave no trigger");
   a_ext_fall_ignore: assert property (@(posedge pclk) disable iff (!presetn)
      (src_reg == TSSL_SRC_EXTERNAL && !ext_trig_in && $stable(src_reg)) |=> !playback_trigger)
      else $error("trigger without external rising edge");
   a_sys_trig: assert property (@(posedge pclk) disable iff (!presetn)
      (src_reg == TSSL_SRC_SYSTEM && $rose(sys_trig_in) && $stable(src_reg)) |=> playback_trigger)
      else $error("system trigger lost");
   a_sw_trig: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == TSSL_SWTRIG_OFF && pwdata[0] && src_reg == TSSL_SRC_SOFTWARE) |-> ##2 playback_trigger)
      else $error("software trigger lost");
   a_sw_only_src: assert property (@(posedge pclk) disable iff (!presetn)
      (src_reg == TSSL_SRC_SOFTWARE && !sw_trig_reg) |=> !playback_trigger)
      else $error("trigger from unselected source in software mode");
   a_int_only_src: assert property (@(posedge pclk) disable iff (!presetn)
      (src_reg == TSSL_SRC_INTERNAL && !int_tick) |=> !playback_trigger)
      else $error("trigger from unselected source in internal mode");
   a_sfp_dark: assert property (@(posedge pclk) disable iff (!presetn)
      (comm_in.sfp_fail && !comm_fatal_reg && !comm_in.comm_fatal) |=> comm_status_lamp == '0)
      else $error("comm lamp lit during port failure");
   a_comm_fatal_hold: assert property (@(posedge pclk) disable iff (!presetn)
      comm_fatal_reg |=> comm_fatal_reg && comm_status_lamp.red && !comm_status_lamp.green)
      else $error("comm fatal not held red");
   a_cache_fatal_red: assert property (@(posedge pclk) disable iff (!presetn)
      play_in.cache_fatal |=> ##1 (playback_status_lamp.red && !playback_status_lamp.green) [*2])
      else $error("playback lamp not red after cache fatal");
   a_idle_dark: assert property (@(posedge pclk) disable iff (!presetn)
      (!play_en_reg && !cache_fatal_reg && $stable(play_en_reg)) |=> playback_status_lamp == '0)
      else $error("playback lamp lit while idle");
   a_steady_green: assert property (@(posedge pclk) disable iff (!presetn)
      (play_en_reg && !notrig_reg && !play_in.cache_stall && !cache_fatal_reg) |=> playback_status_lamp.green)
      else $error("playback lamp not green while playing");
   a_link_green: assert property (@(posedge pclk) disable iff (!presetn)
      (!comm_fatal_reg && !comm_in.sfp_fail && comm_in.eth_link && !comm_in.frame_activity)
      |=> comm_status_lamp.green && !comm_status_lamp.red)
      else $error("comm lamp not steady green with link up");
   a_nolink_breathe: assert property (@(posedge pclk) disable iff (!presetn)
      (!comm_fatal_reg && !comm_in.sfp_fail && !comm_in.eth_link) |=> !comm_status_lamp.red && comm_status_lamp.green == $past(breathe))
      else $error("comm lamp not breathing without link");
   a_activity_blink: assert property (@(posedge pclk) disable iff (!presetn)
      (!comm_fatal_reg && !comm_in.sfp_fail && comm_in.eth_link && comm_in.frame_activity)
      |=> !comm_status_lamp.red && comm_status_lamp.green == $past(blink))
      else $error("comm lamp not blinking during activity");
   a_stall_blink_red: assert property (@(posedge pclk) disable iff (!presetn)
      (!cache_fatal_reg && play_en_reg && play_in.cache_stall)
      |=> !playback_status_lamp.green && playback_status_lamp.red == $past(blink))
      else $error("playback lamp not blinking red on stall");
   a_notrig_breathe: assert property (@(posedge pclk) disable iff (!presetn)
      (!cache_fatal_reg && play_en_reg && !play_in.cache_stall && notrig_reg)
      |=> !playback_status_lamp.red && playback_status_lamp.green == $past(breathe))
      else $error("playback lamp not breathing without trigger");
   a_cache_fatal_hold: assert property (@(posedge pclk) disable iff (!presetn)
      cache_fatal_reg |=> cache_fatal_reg && playback_status_lamp.red && !playback_status_lamp.green)
      else $error("cache fatal not held red");
   a_irq_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == TSSL_IRQ_CLR_OFF && playback_trigger) |=> irq_stat_reg[TSSL_IRQ_TRIG])
      else $error("trigger status lost to a clear in the same cycle");
   a_bad_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && !addr_ok) |=> prdata == 32'h0)
      else $error("unmapped read returned data");

   c_ext_trigger: cover property (@(posedge pclk) src_reg == TSSL_SRC_EXTERNAL && playback_trigger);
   c_int_trigger: cover property (@(posedge pclk) src_reg == TSSL_SRC_INTERNAL && playback_trigger);
   c_notrig: cover property (@(posedge pclk) notrig_reg);
   c_sw_trigger: cover property (@(posedge pclk) src_reg == TSSL_SRC_SOFTWARE && playback_trigger);
   c_stall_blink: cover property (@(posedge pclk) play_en_reg && play_in.cache_stall && !cache_fatal_reg);
endmodule

`default_nettype wire

/* File: testbench/tssl_trig_src.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// far side: external trigger source and distribution unit
// ----------------------------------------------------------------
module tssl_trig_src (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // requests from the bench
   input wire logic fire_ext,
   input wire logic fire_sys,
   // trigger lines
   output logic ext_trig_in,
   output logic sys_trig_in
);
   logic [2:0] ext_reg;
   logic [2:0] sys_reg;

   // each request gives a three-cycle high pulse, then the line rests low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_reg <= 3'h0;
         sys_reg <= 3'h0;
      end else begin
         ext_reg <= fire_ext ? 3'h7 : {ext_reg[1:0], 1'b0};
         sys_reg <= fire_sys ? 3'h7 : {sys_reg[1:0], 1'b0};
      end
   end

   assign ext_trig_in = ext_reg[2];
   assign sys_trig_in = sys_reg[2];
endmodule
`default_nettype wire

/* File: testbench/tssl_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tssl_top_tb;
   import tssl_pkg::*;
   localparam int LIMIT = 20000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
   logic fire_ext, fire_sys, ext_trig_in, sys_trig_in, playback_trigger;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   tssl_comm_in_t comm_in;
   tssl_play_in_t play_in;
   tssl_lamp_t comm_status_lamp, playback_status_lamp;
   int n_fail, n_tests, cyc, n_trig, t_prev, t_last;

   // short counts keep the lamp patterns within reach
   tssl_top #(.NOTRIG_CYC(50), .BLINK_CYC(4), .BREATH_CYC(1024)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_trig_in(ext_trig_in), .sys_trig_in(sys_trig_in), .comm_in(comm_in), .play_in(play_in),
      .playback_trigger(playback_trigger), .comm_status_lamp(comm_status_lamp),
      .playback_status_lamp(playback_status_lamp), .irq(irq));

   tssl_trig_src u_far (
      .pclk(pclk), .presetn(presetn), .fire_ext(fire_ext), .fire_sys(fire_sys),
      .ext_trig_in(ext_trig_in), .sys_trig_in(sys_trig_in));

   // ----------------------------------------------------------------
   // clock, cycle count, trigger log, hang guard
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc++;
      if (playback_trigger === 1'b1) begin
         n_trig++;
         t_prev = t_last;
         t_last = cyc;
      end
      if (cyc == LIMIT) begin
         n_fail++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic fire(input logic e, input logic s);
      @(posedge pclk);
      fire_ext <= e;
      fire_sys <= s;
      @(posedge pclk);
      fire_ext <= 1'b0;
      fire_sys <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask

   // set status inputs, then note which lamp levels appear: {g1, g0, r1, r0}
   task automatic lamp(input logic sel, input logic [3:0] v, input int n, input logic [3:0] exp, input string what);
      logic [3:0] seen;
      tssl_lamp_t l;
      seen = 4'h0;
      @(posedge pclk);
      if (sel) play_in <= tssl_play_in_t'(v[1:0]);
      else comm_in <= tssl_comm_in_t'(v);
      repeat (3) @(posedge pclk);
      repeat (n) begin
         @(posedge pclk);
         l = sel ? playback_status_lamp : comm_status_lamp;
         seen |= {l.green === 1'b1, l.green === 1'b0, l.red === 1'b1, l.red === 1'b0};
      end
      chk(what, {28'h0, seen}, {28'h0, exp});
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      apb(1'b0, TSSL_CTRL_OFF, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      apb(1'b0, TSSL_INTERVAL_OFF, 32'h0);
      chk("interval reset", rd, TSSL_INTERVAL_RST);
      apb(1'b0, 12'h0FC, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      chk("unmapped read", rd, 32'h0);
      lamp(1'b1, 4'h0, 20, 4'b0101, "idle lamp");
   endtask

   task automatic t_edge();
      int n0;
      for (int s = 1; s <= 3; s++) begin
         apb(1'b1, TSSL_CTRL_OFF, 32'h4 | 32'(s));
         n0 = n_trig;
         fire(1'b1, 1'b0);
         fire(1'b0, 1'b1);
         chk("edge triggers", 32'(n_trig - n0), (s < 3) ? 32'h1 : 32'h0);
      end
      n0 = n_trig;
      apb(1'b1, TSSL_SWTRIG_OFF, 32'h1);
      repeat (4) @(posedge pclk);
      chk("software trigger", 32'(n_trig - n0), 32'h1);
   endtask

   task automatic t_internal();
      logic [31:0] iv [3] = '{32'h0, 32'h1, 32'h5};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, TSSL_INTERVAL_OFF, iv[i]);
         apb(1'b1, TSSL_CTRL_OFF, 32'h4);
         repeat (20) @(posedge pclk);
         chk("interval gap", 32'(t_last - t_prev), (iv[i] == 32'h0) ? 32'h1 : iv[i]);
         if (i == 0) begin
            // clear while a trigger fires every cycle: the set must win
            apb(1'b1, TSSL_IRQ_CLR_OFF, 32'h1);
            apb(1'b0, TSSL_IRQ_STAT_OFF, 32'h0);
            chk("set wins over clear", rd & 32'h1, 32'h1);
         end
         apb(1'b1, TSSL_CTRL_OFF, 32'h5);
      end
   endtask

   task automatic t_irq();
      apb(1'b1, TSSL_IRQ_CLR_OFF, 32'hF);
      apb(1'b1, TSSL_IRQ_EN_OFF, 32'h1);
      fire(1'b1, 1'b0);
      chk("irq raised", {31'h0, irq}, 32'h1);
      apb(1'b1, TSSL_IRQ_EN_OFF, 32'h0);
      @(posedge pclk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b1, TSSL_IRQ_CLR_OFF, 32'h1);
      apb(1'b0, TSSL_IRQ_STAT_OFF, 32'h0);
      chk("irq cleared", rd & 32'h1, 32'h0);
   endtask

   task automatic t_comm();
      lamp(1'b0, 4'h8, 20, 4'b0101, "port failure");
      lamp(1'b0, 4'h0, 1100, 4'b1101, "no link");
      lamp(1'b0, 4'h4, 40, 4'b1001, "link up");
      lamp(1'b0, 4'h6, 40, 4'b1101, "frame activity");
      lamp(1'b0, 4'h7, 40, 4'b0110, "comm fatal");
      lamp(1'b0, 4'h4, 40, 4'b0110, "comm fatal held");
   endtask

   task automatic t_play();
      apb(1'b1, TSSL_CTRL_OFF, 32'h7);
      apb(1'b1, TSSL_SWTRIG_OFF, 32'h1);
      lamp(1'b1, 4'h0, 30, 4'b1001, "playing");
      lamp(1'b1, 4'h0, 1200, 4'b1101, "no trigger");
      lamp(1'b1, 4'h1, 40, 4'b0111, "cache stall");
      lamp(1'b1, 4'h3, 40, 4'b0110, "cache fatal");
      lamp(1'b1, 4'h0, 40, 4'b0110, "cache fatal held");
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      fire_ext = 1'b0;
      fire_sys = 1'b0;
      comm_in = tssl_comm_in_t'(4'h4);
      play_in = tssl_play_in_t'(2'h0);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_edge();
      t_internal();
      t_irq();
      t_comm();
      t_play();
      summarize();
   end
endmodule
`default_nettype wire
